// ### inc/cvg_regs.svh
// Purpose: constants of the character video generator
// Assumes: one 100 MHz clock, dot pacing by a one-cycle dot tick
// Notes:   offsets, field positions, reset values and counts
`ifndef CVG_REGS_SVH
`define CVG_REGS_SVH

`define CVG_DOTS_PER_CELL 3'h6
`define CVG_LOAD_COL      3'h5
`define CVG_LINES_PER_ROW 4'ha
`define CVG_LAST_LINE     4'h9
`define CVG_DESC_LINE     4'h8
`define CVG_DESC_HIDE     4'h2
`define CVG_COLS          7'h50
`define CVG_ROWS          5'h18

`define CVG_OFF_CTRL      4'h0
`define CVG_OFF_STAT      4'h4
`define CVG_OFF_COL       4'h8

`define CVG_CTRL_BLANK    0
`define CVG_CTRL_DESC     1
`define CVG_CTRL_INT      2
`define CVG_CTRL_RESET    3'h6

`define CVG_DESC_G        7'h67
`define CVG_DESC_J        7'h6a
`define CVG_DESC_P        7'h70
`define CVG_DESC_Q        7'h71
`define CVG_DESC_Y        7'h79

`endif

// ### inc/cvg_pkg.sv
// Purpose: types shared by the character video generator
// Assumes: constants come from the register header
// Notes:   structs carry grouped signals between modules
`include "cvg_regs.svh"

package cvg_pkg;

  // one refresh memory word
  typedef struct packed {
    logic       intensity;
    logic       cursor;
    logic [6:0] code;
  } cvg_char_t;

  // composite video to the output follower
  typedef struct packed {
    logic       dot;
    logic       cursor;
    logic [1:0] level;
  } cvg_video_t;

  // software control bits
  typedef struct packed {
    logic intEnable;
    logic descEnable;
    logic forceBlank;
  } cvg_ctrl_t;

  function automatic logic cvg_is_descender(input logic [6:0] code);
    return (code == `CVG_DESC_G) || (code == `CVG_DESC_J) ||
           (code == `CVG_DESC_P) || (code == `CVG_DESC_Q) ||
           (code == `CVG_DESC_Y);
  endfunction : cvg_is_descender

endpackage : cvg_pkg

// ### verilog/cvg_glyph_rom.sv
// Purpose: glyph lookup table, code and scan line to dot row
// Assumes: address already holds code low, line bits high
// Notes:   sample font: one capital, two rows of one descender; rest blank
module cvg_glyph_rom
  import cvg_pkg::*;
(
  // lookup
  input  wire logic [9:0] addr,
  output logic      [4:0] dots
);

  ////////////////////////////////////////////////////////////////////
  // bit n of a word is dot n+1 of the cell, dot 6 has no bit
  always_comb begin
    case (addr)
      10'h0c1: dots = 5'h04;
      10'h141: dots = 5'h0a;
      10'h1c1: dots = 5'h11;
      10'h241: dots = 5'h11;
      10'h2c1: dots = 5'h1f;
      10'h341: dots = 5'h11;
      10'h3c1: dots = 5'h11;
      // descender rows, so the line 8 and 9 wrap shows something
      10'h0e7: dots = 5'h1e;
      10'h167: dots = 5'h11;
      default: dots = 5'h00;
    endcase
  end

endmodule : cvg_glyph_rom

// ### verilog/cvg_video_gen.sv
// Purpose: character cell video generator, 6 x 10 cells, 24 x 80 grid
// Assumes: dot tick, line and frame pulses from the sync generator
// Notes:   memory word must follow charAdvance by the next load strobe, six dot ticks later
`include "cvg_regs.svh"

module cvg_video_gen
  import cvg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // sync generator
  input  wire logic        dotTick,
  input  wire logic        lineStart,
  input  wire logic        frameStart,
  input  wire logic        dotEnable,
  // processor blanking pin
  input  wire logic        displayBlankLine,
  // refresh memory
  input  wire cvg_char_t   charWord,
  output logic             charAdvance,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // video
  output cvg_video_t       videoOut
);

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic [1:0]  blankSync_q;
  logic        blankS;
  cvg_ctrl_t   ctrl_q;
  logic [7:0]  rdata_q;
  logic [2:0]  dotCol_q;
  logic [3:0]  scanLine_q;
  logic [6:0]  cellCount_q;
  cvg_char_t   charLatch_q;
  logic [5:0]  dotShifter_q;
  logic        shiftCursor_q;
  logic        shiftInt_q;
  logic        shiftDesc_q;
  logic [9:0]  romAddr;
  logic [4:0]  romDots;
  logic [4:0]  glyphRow;
  logic        cellLoad;
  logic        descGate;
  logic        gateOpen;
  logic        dotG;
  logic        curG;
  cvg_video_t  video_q;

  ////////////////////////////////////////////////////////////////////
  // processor blank arrives from another domain, two flops first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blankSync_q <= 2'h0;
    end else if (ce) begin
      blankSync_q <= {blankSync_q[0], displayBlankLine};
    end
  end

  assign blankS = blankSync_q[1] | ctrl_q.forceBlank;

  ////////////////////////////////////////////////////////////////////
  // register port, read data only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `CVG_CTRL_RESET;
    end else if (ce && regWr && regAddr == `CVG_OFF_CTRL) begin
      ctrl_q.forceBlank <= regWdata[`CVG_CTRL_BLANK];
      ctrl_q.descEnable <= regWdata[`CVG_CTRL_DESC];
      ctrl_q.intEnable  <= regWdata[`CVG_CTRL_INT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `CVG_OFF_CTRL: rdata_q <= {5'h00, ctrl_q};
          `CVG_OFF_STAT: rdata_q <= {1'b0, dotCol_q, scanLine_q};
          `CVG_OFF_COL:  rdata_q <= {1'b0, cellCount_q};
          default:       rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign regRdata = rdata_q;

  ////////////////////////////////////////////////////////////////////
  // dot column within the cell; load strobe on the sixth dot
  assign cellLoad = ce && dotTick && (dotCol_q == `CVG_LOAD_COL);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dotCol_q <= 3'h0;
    end else if (ce) begin
      if (lineStart) begin
        dotCol_q <= 3'h0;
      end else if (cellLoad) begin
        dotCol_q <= 3'h0;
      end else if (dotTick) begin
        dotCol_q <= dotCol_q + 3'h1;
      end
    end
  end

  // cells loaded on this line, readable for bring-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cellCount_q <= 7'h00;
    end else if (ce) begin
      if (lineStart) begin
        cellCount_q <= 7'h00;
      end else if (cellLoad && cellCount_q != `CVG_COLS) begin
        cellCount_q <= cellCount_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // scan line counter, modulo ten
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scanLine_q <= 4'h0;
    end else if (ce) begin
      if (frameStart) begin
        scanLine_q <= 4'h0;
      end else if (lineStart) begin
        if (scanLine_q == `CVG_LAST_LINE) begin
          scanLine_q <= 4'h0;
        end else begin
          scanLine_q <= scanLine_q + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // glyph lookup from the latch outputs; lines 8 and 9 wrap onto
  // rows 0 and 1 through the low three counter bits
  assign romAddr = {scanLine_q[2:0], charLatch_q.code};

  cvg_glyph_rom u_glyph_rom (
    .addr (romAddr),
    .dots (romDots)
  );

  // row 0 forced blank so a bad font cannot merge rows
  assign glyphRow = (romAddr[9:7] == 3'h0) ? 5'h00 : romDots;

  ////////////////////////////////////////////////////////////////////
  // character latch: memory word for the character after the shifter
  // memory steps on the same strobe, so it reads two cells ahead
  assign charAdvance = cellLoad;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charLatch_q <= '0;
    end else if (cellLoad) begin
      charLatch_q <= charWord;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dot shifter, dot 1 on bit 0 so the cell goes out left to right
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dotShifter_q <= 6'h00;
    end else if (ce && dotTick) begin
      if (cellLoad) begin
        dotShifter_q <= {1'b0, glyphRow};
      end else begin
        dotShifter_q <= {1'b0, dotShifter_q[5:1]};
      end
    end
  end

  // attributes travel with the pattern, one cell behind the latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftCursor_q <= 1'b0;
      shiftInt_q    <= 1'b0;
      shiftDesc_q   <= 1'b0;
    end else if (cellLoad) begin
      shiftCursor_q <= charLatch_q.cursor;
      shiftInt_q    <= charLatch_q.intensity;
      shiftDesc_q   <= cvg_is_descender(charLatch_q.code)
                       && ctrl_q.descEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // descender gate: descenders start two lines down and wrap onto 8 and 9, others stop at 8
  always_comb begin
    if (shiftDesc_q) begin
      descGate = (scanLine_q >= `CVG_DESC_HIDE);
    end else begin
      descGate = (scanLine_q < `CVG_DESC_LINE);
    end
  end

  // dot enable low outside the 24 x 80 area
  assign gateOpen = dotEnable && !blankS;
  assign dotG     = dotShifter_q[0] && gateOpen && descGate;
  // cursor ignores the descender gate so it can fill lines 8 and 9
  assign curG     = shiftCursor_q && gateOpen;

  ////////////////////////////////////////////////////////////////////
  // output stage: dots, full-intensity copy and cursor summed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      video_q <= '0;
    end else if (ce) begin
      video_q.dot    <= dotG;
      video_q.cursor <= curG;
      video_q.level  <= {1'b0, dotG}
                        + {1'b0, dotG && shiftInt_q && ctrl_q.intEnable}
                        + {1'b0, curG};
    end
  end

  assign videoOut = video_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sLoad;
    ce && dotTick && dotCol_q == `CVG_LOAD_COL;
  endsequence

  sequence sShift;
    ce && dotTick && dotCol_q != `CVG_LOAD_COL && !lineStart;
  endsequence

  sequence sClosed;
    ce && (!dotEnable || blankS);
  endsequence

  a_load_sixth: assert property (
    cellLoad |-> dotCol_q == 3'h5 && dotTick)
    else $error("load strobe away from sixth dot");

  a_load_pattern: assert property (
    sLoad |=> dotShifter_q[4:0] == $past(glyphRow))
    else $error("shifter not loaded with glyph row");

  a_col_blank: assert property (
    dotCol_q == `CVG_LOAD_COL |-> !dotShifter_q[0])
    else $error("dot column six not blank");

  a_latch_word: assert property (
    sLoad |=> charLatch_q == $past(charWord))
    else $error("latch missed memory word");

  a_rom_ahead: assert property (
    sLoad ##1 (romAddr[6:0] == charLatch_q.code)
      |-> shiftCursor_q == $past(charLatch_q.cursor))
    else $error("pipeline order broken");

  a_shift_out: assert property (
    sShift |=> dotShifter_q[4:0] == $past(dotShifter_q[5:1]))
    else $error("shifter did not step one dot");

  a_scan_wrap: assert property (
    ce && lineStart && !frameStart && scanLine_q == 4'h9
      |=> scanLine_q == 4'h0)
    else $error("scan line did not wrap after nine");

  a_scan_range: assert property (
    scanLine_q <= 4'h9)
    else $error("scan line out of range");

  a_blank_dot: assert property (
    sClosed |=> !videoOut.dot && !videoOut.cursor)
    else $error("video while gated off");

  a_desc_early: assert property (
    ce && shiftDesc_q && scanLine_q < 4'h2 |=> !videoOut.dot)
    else $error("descender shown on early lines");

  a_desc_late: assert property (
    ce && !shiftDesc_q && scanLine_q >= 4'h8 |=> !videoOut.dot)
    else $error("plain character shown on lines 8 or 9");

  a_row_zero: assert property (
    romAddr[9:7] == 3'h0 |-> glyphRow == 5'h00)
    else $error("glyph row zero not blank");

  a_cursor_gate: assert property (
    ce && shiftCursor_q && dotEnable && !blankS |=> videoOut.cursor)
    else $error("open cursor not shown");

  a_level_sum: assert property (
    !videoOut.dot |-> videoOut.level == {1'b0, videoOut.cursor})
    else $error("level without dots wrong");

  a_read_once: assert property (
    ce && !regRd |=> regRdata == 8'h00)
    else $error("read data outside answer cycle");

  a_read_ctrl: assert property (
    ce && regRd && regAddr == `CVG_OFF_CTRL |=> regRdata == {5'h00, $past(ctrl_q)})
    else $error("control read back wrong");

  a_desc_show: assert property (
    ce && shiftDesc_q && scanLine_q >= 4'h8 && dotShifter_q[0] && dotEnable && !blankS
      |=> videoOut.dot)
    else $error("descender row missing on lines 8 or 9");

  a_dot_follow: assert property (
    ce && gateOpen && descGate |=> videoOut.dot == $past(dotShifter_q[0]))
    else $error("open gate did not pass shifter dot");

  a_int_level: assert property (
    ce && dotG && shiftInt_q && ctrl_q.intEnable && !curG |=> videoOut.level == 2'h2)
    else $error("full intensity copy not summed");

  a_shift_hold: assert property (
    !dotTick |=> $stable(dotShifter_q))
    else $error("shifter moved without a dot tick");

  a_count_sat: assert property (
    cellCount_q <= `CVG_COLS)
    else $error("cell count beyond eighty");

  // frozen enable must hold dot column, scan line, shifter, latch and video output
  a_ce_freeze: assert property (
    !ce |=> $stable(dotCol_q) && $stable(scanLine_q) && $stable(dotShifter_q)
      && $stable(charLatch_q) && $stable(videoOut))
    else $error("state moved while clock enable low");

endmodule : cvg_video_gen

// ### verif/cvg_sync_mem_model.sv
// Purpose: sync generator and refresh memory facing the video generator
// Assumes: one clock domain, pulses driven just after a rising edge
// Notes:   memory word steps on every load, so it runs two cells ahead of video
`include "cvg_regs.svh"

module cvg_sync_mem_model
  import cvg_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_b,
  // sync generator
  output logic           dotTick,
  output logic           lineStart,
  output logic           frameStart,
  output logic           dotEnable,
  // refresh memory
  input  wire logic      charAdvance,
  output cvg_char_t      charWord
);
  timeunit 1ns;
  timeprecision 1ps;

  cvg_char_t  mem [0:127];
  logic [6:0] ptr_q;

  initial begin
    dotTick    = 1'b0;
    lineStart  = 1'b0;
    frameStart = 1'b0;
    dotEnable  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // word pointer restarts each line, steps on each load strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= 7'h00;
    end else if (lineStart) begin
      ptr_q <= 7'h00;
    end else if (charAdvance) begin
      ptr_q <= ptr_q + 7'h01;
    end
  end

  assign charWord = mem[ptr_q];

  ////////////////////////////////////////////////////////////////////////////
  // area enable held for the whole line, so gating is stable per line
  task automatic line_start(input bit frame, input bit en);
    @(posedge clk);
    lineStart  <= 1'b1;
    frameStart <= frame;
    dotEnable  <= en;
    @(posedge clk);
    lineStart  <= 1'b0;
    frameStart <= 1'b0;
  endtask : line_start

  // one tick every four cycles leaves room to sample settled video
  task automatic dot_tick();
    @(posedge clk);
    dotTick <= 1'b1;
    @(posedge clk);
    dotTick <= 1'b0;
    @(posedge clk);
    @(posedge clk);
  endtask : dot_tick

endmodule : cvg_sync_mem_model

// ### verif/character_video_generator_tb.sv
// Purpose: self-checking bench of the character video generator
// Assumes: sample font holds code 41 and rows 1 and 2 of descender code 67
// Notes:   first two cells of each line show the leftover shifter and latch and are not checked
`include "cvg_regs.svh"

module character_video_generator_tb import cvg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rst_b;
  logic       ce;
  logic       dotTick;
  logic       lineStart;
  logic       frameStart;
  logic       dotEnable;
  logic       displayBlankLine;
  cvg_char_t  charWord;
  logic       charAdvance;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  cvg_video_t videoOut;
  int         mismatches;
  int         n_checks;
  int         ticks;
  integer     seed;
  logic [3:0] scanLine;
  logic       blkPin;
  logic       forceB;
  logic       intEn;
  logic       descEn;

  cvg_video_gen cvg_video_gen_i (.clk(clk), .rst_b(rst_b), .ce(ce), .dotTick(dotTick),
    .lineStart(lineStart), .frameStart(frameStart), .dotEnable(dotEnable),
    .displayBlankLine(displayBlankLine), .charWord(charWord), .charAdvance(charAdvance),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .videoOut(videoOut));

  cvg_sync_mem_model cvg_sync_mem_model_i (.clk(clk), .rst_b(rst_b), .dotTick(dotTick),
    .lineStart(lineStart), .frameStart(frameStart), .dotEnable(dotEnable),
    .charAdvance(charAdvance), .charWord(charWord));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] fontRow(input logic [2:0] r);
    case (r)
      3'h1:    return 5'h04;
      3'h2:    return 5'h0a;
      3'h5:    return 5'h1f;
      3'h0:    return 5'h00;
      default: return 5'h11;
    endcase
  endfunction : fontRow

  function automatic cvg_video_t expVid(input cvg_char_t c, input logic [3:0] ln, input int d);
    logic [4:0] row;
    logic       show;
    logic       b;
    logic       g;
    row  = (c.code == 7'h41) ? fontRow(ln[2:0]) :
           (c.code == `CVG_DESC_G && ln[2:0] == 3'h1) ? 5'h1e :
           (c.code == `CVG_DESC_G && ln[2:0] == 3'h2) ? 5'h11 : 5'h00;
    show = (descEn && (c.code inside {`CVG_DESC_G, `CVG_DESC_J, `CVG_DESC_P, `CVG_DESC_Q,
            `CVG_DESC_Y})) ? (ln >= 4'h2) : (ln < `CVG_DESC_LINE);
    b    = show && (d <= 5) && ((d <= 5) ? row[d-1] : 1'b0);
    g    = dotEnable && !blkPin && !forceB;
    return '{dot: b & g, cursor: c.cursor & g,
             level: 2'(b & g) + 2'(b & g & c.intensity & intEn) + 2'(c.cursor & g)};
  endfunction : expVid

  task automatic chk_video(input cvg_video_t e);
    n_checks++;
    if (videoOut !== e) begin
      mismatches++;
      $display("BAD t=%0t video %h expected %h", $time, videoOut, e);
    end
  endtask : chk_video

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] e);
    n_checks++;
    if (got !== e) begin
      mismatches++;
      $display("BAD t=%0t register %h expected %h", $time, got, e);
    end
  endtask : chk_byte

  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : reg_write

  // data stand only in the cycle after the strobe, then read as zero
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk_byte(regRdata, e);
    @(posedge clk);
    #1 chk_byte(regRdata, 8'h00);
  endtask : reg_read

  // a frozen tick must not count, so the last dot is expected again
  task automatic tick(input bit fr);
    fork
      cvg_sync_mem_model_i.dot_tick();
      if (fr) begin
        @(posedge clk) ce <= 1'b0;
        @(posedge clk) ce <= 1'b1;
      end
    join
    if (!fr) ticks++;
    #1;
    if (ticks >= 12)
      chk_video(expVid(cvg_sync_mem_model_i.mem[ticks/6-2], scanLine, ticks%6+1));
  endtask : tick

  task automatic run_line(input bit frame, input bit en, input bit blk, input int n, input bit frz);
    @(posedge clk);
    blkPin           = blk;
    displayBlankLine <= blk;
    cvg_sync_mem_model_i.line_start(frame, en);
    scanLine = (frame || scanLine == 4'h9) ? 4'h0 : scanLine + 4'h1;
    ticks    = 0;
    reg_read(`CVG_OFF_STAT, {4'h0, scanLine});
    for (int i = 0; i < n * 6; i++) tick(frz && i == 20);
    // a frozen tick drops one load, so count from the ticks really given
    reg_read(`CVG_OFF_COL, (ticks / 6 > 80) ? 8'h50 : 8'(ticks / 6));
  endtask : run_line

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0; ce = 1'b1; displayBlankLine = 1'b0; regAddr = 4'h0; regWdata = 8'h00;
    regWr = 1'b0; regRd = 1'b0; mismatches = 0; n_checks = 0; seed = 83; scanLine = 4'h0;
    blkPin = 1'b0; forceB = 1'b0; intEn = 1'b1; ticks = 0; descEn = 1'b1;
    for (int i = 0; i < 128; i++)
      cvg_sync_mem_model_i.mem[i] = '{intensity: 1'($random(seed)), cursor: 1'($random(seed)),
        code: (($random(seed) & 3) != 0) ? 7'h41 : 7'($random(seed))};
    cvg_sync_mem_model_i.mem[2].code = `CVG_DESC_G;
    cvg_sync_mem_model_i.mem[5].code = `CVG_DESC_Y;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(`CVG_OFF_CTRL, 8'h06);
    reg_read(4'hc, 8'h00);
    reg_write(4'hc, 8'hff);
    reg_read(`CVG_OFF_CTRL, 8'h06);
    run_line(1'b1, 1'b1, 1'b0, 10, 1'b0);
    // eleven more lines wrap the scan line count once
    for (int l = 1; l < 12; l++)
      // lines 1 and 9 kept open so the descender shift is seen
      run_line(1'b0, (($random(seed) & 3) != 0) || (l inside {1, 9}),
               (($random(seed) % 5) == 0) && !(l inside {1, 9}), 10, l == 3);
    run_line(1'b0, 1'b1, 1'b0, 82, 1'b0);
    reg_write(`CVG_OFF_CTRL, 8'h07);
    forceB = 1'b1;
    reg_read(`CVG_OFF_CTRL, 8'h07);
    run_line(1'b0, 1'b1, 1'b0, 10, 1'b0);
    reg_write(`CVG_OFF_CTRL, 8'h02);
    forceB = 1'b0;
    intEn  = 1'b0;
    run_line(1'b0, 1'b1, 1'b0, 10, 1'b0);
    // descender handling off: rows keep their own lines, checked on lines 0 and 1 only
    reg_write(`CVG_OFF_CTRL, 8'h04);
    descEn = 1'b0;
    intEn  = 1'b1;
    reg_read(`CVG_OFF_CTRL, 8'h04);
    run_line(1'b1, 1'b1, 1'b0, 10, 1'b0);
    run_line(1'b0, 1'b1, 1'b0, 10, 1'b0);
    end_of_test();
  end

endmodule : character_video_generator_tb
